// ===== verification/hles_link3_event_status_assertions.sv
module hles_link3_event_status_checker
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [hles_pkg::BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic send_begin_flag,
   input wire logic receive_begin_flag,
   input wire logic send_done_flag,
   input wire logic receive_done_flag,
   input wire logic checksum_fault_flag,
   input wire logic abort_seen_flag,
   input wire logic flag_octet_seen,
   input wire logic irq
);
   import hles_pkg::*;
   logic rdTake;
   logic wrTake;
   logic anyEvent;
   // Irq may only move after a bus take or an event pulse
   assign rdTake = s_axi_arvalid && s_axi_arready;
   assign wrTake = (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
   assign anyEvent = |{send_begin_flag, receive_begin_flag, send_done_flag, receive_done_flag,
                       checksum_fault_flag, abort_seen_flag, flag_octet_seen};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence statusRead;
      rdTake && s_axi_araddr == STATUS_ADDR;
   endsequence
   sequence unmappedRead;
      rdTake && s_axi_araddr != STATUS_ADDR && s_axi_araddr != ENABLE_ADDR;
   endsequence
   rd_answer_a: assert property (rdTake |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("taken while busy");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write not answered");
   bad_read_a: assert property (unmappedRead |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read accepted");
   enable_read_a: assert property (rdTake && s_axi_araddr == ENABLE_ADDR |=> s_axi_rdata[31:7] == 25'h0)
      else $error("enable top bits not zero");
   status_read_a: assert property (statusRead |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
      else $error("status read malformed");
   irq_rise_a: assert property ($rose(irq) |-> $past(anyEvent) || $past(wrTake) || $past(wrTake, 2))
      else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(rdTake && s_axi_araddr == STATUS_ADDR) || $past(wrTake)
      || $past(wrTake, 2)) else $error("irq fell without cause");
endmodule : hles_link3_event_status_checker

bind hles_link3_event_status hles_link3_event_status_checker chk_u (.*);

// ===== verification/hles_link3_event_status_test.sv
module hles_link3_event_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   import hles_pkg::*;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [BUS_ADDR_W-1:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [6:0] ev = 7'h0;
   logic received_message_kind = 1'h0;
   wire send_begin_flag, receive_begin_flag, send_done_flag, receive_done_flag;
   wire checksum_fault_flag, abort_seen_flag, flag_octet_seen;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int num_errors = 0;
   int num_checks = 0;
   // Event vector laid out in status bit order, bit 6 down to bit 0
   assign {send_begin_flag, receive_begin_flag, send_done_flag, receive_done_flag, checksum_fault_flag,
           abort_seen_flag, flag_octet_seen} = ev;
   hles_link3_event_status dut_u (.*);
   initial forever #25 core_clk = ~core_clk;
   // ==========================================================
   // Bus, event and check tasks
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   // Each channel is released at the edge that takes it
   task automatic wr(input logic [BUS_ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // Ends once s_axi_bvalid is seen; the watchdog catches a hang
      forever
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'h0;
      check(s_axi_bvalid, 1'h1, "write answer");
      check(s_axi_bresp, er, "write resp");
   endtask : wr
   task automatic rd(input logic [BUS_ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'h0;
      check(s_axi_rvalid, 1'h1, "read answer");
      check(s_axi_rdata, ed, "read data");
      check(s_axi_rresp, er, "read resp");
   endtask : rd
   // One-cycle event pulse; waits past the edge so irq has settled
   task automatic pulse(input logic [6:0] v, input logic kind);
      @(posedge core_clk);
      ev <= v;
      received_message_kind <= kind;
      @(posedge core_clk);
      ev <= 7'h0;
      #1;
   endtask : pulse
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs();
      check(irq, 1'h0, "irq after reset");
      rd(STATUS_ADDR, 32'h0, RESP_OKAY);
      rd(ENABLE_ADDR, 32'h0, RESP_OKAY);
      wr(ENABLE_ADDR, 32'hFF, RESP_OKAY);
      rd(ENABLE_ADDR, 32'h7F, RESP_OKAY);
      wr(STATUS_ADDR, 32'hFF, RESP_OKAY);
      rd(STATUS_ADDR, 32'h0, RESP_OKAY);
      wr(STATUS_ADDR - 14'h4, 32'hFF, RESP_SLVERR);
      rd(STATUS_ADDR - 14'h4, 32'h0, RESP_SLVERR);
      wr(ENABLE_ADDR, 32'h0, RESP_OKAY);
      $display("register test done");
   endtask : t_regs
   task automatic t_events();
      for (int i = 0; i < 7; i++)
      begin
         pulse(7'h1 << i, 1'h0);
         check(irq, 1'h0, "masked irq");
         rd(STATUS_ADDR, 32'h1 << i, RESP_OKAY);
         rd(STATUS_ADDR, 32'h0, RESP_OKAY);
      end
      $display("event test done");
   endtask : t_events
   // A neighbouring event must not raise irq; the enabled one must
   task automatic t_irq();
      for (int i = 0; i < 7; i++)
      begin
         wr(ENABLE_ADDR, 32'h1 << i, RESP_OKAY);
         pulse(7'h1 << ((i + 1) % 7), 1'h0);
         check(irq, 1'h0, "other event gated");
         pulse(7'h1 << i, 1'h0);
         check(irq, 1'h1, "enabled event irq");
         rd(STATUS_ADDR, (32'h1 << i) | (32'h1 << ((i + 1) % 7)), RESP_OKAY);
         check(irq, 1'h0, "irq after read");
      end
      wr(ENABLE_ADDR, 32'h0, RESP_OKAY);
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_kind();
      pulse(7'h08, 1'h1);
      rd(STATUS_ADDR, 32'h88, RESP_OKAY);
      rd(STATUS_ADDR, 32'h80, RESP_OKAY);
      pulse(7'h08, 1'h0);
      rd(STATUS_ADDR, 32'h08, RESP_OKAY);
      rd(STATUS_ADDR, 32'h00, RESP_OKAY);
      $display("message kind test done");
   endtask : t_kind
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // Main sequence, reset held for three cycles
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'h1;
      t_regs();
      t_events();
      t_irq();
      t_kind();
      conclude();
   end
   // Watchdog: the run needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge core_clk);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
endmodule : hles_link3_event_status_test

// ===== verilog/hles_link3_event_status.sv
// Behaviour
// - Status bit 7 shows last received message kind: 0 bit-oriented, 1 message-oriented.
// - Transmit start-of-message event sets status bit 6.
// - Receive start-of-message event sets status bit 5.
// - Transmit end-of-message event sets status bit 4.
// - Receive end-of-message event sets status bit 3.
// - Checksum error on received message sets status bit 2.
// - Seven consecutive ones received set abort status bit 1.
// - Flag octet 0x7E received sets idle status bit 0.
// - Event bits are sticky, clear on status read, reset to zero.
// - Enable bit 6 gates transmit start-of-message interrupt.
// - Enable bit 5 gates receive start-of-message interrupt; 1 enables.
// - Enable bit 4 gates transmit end-of-message interrupt.
// - Enable bit 3 gates receive end-of-message interrupt.
// - Enable bits read/write, reset to zero, top bit reserved.
// - Enable bits 2, 1, 0 gate checksum, abort and idle interrupts.
//
// The implementer's own choice: register access over AXI4-Lite.
module hles_link3_event_status
(
   input wire logic core_clk,
   input wire logic rst_b,
   // AXI4-Lite slave
   input wire logic [hles_pkg::BUS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [hles_pkg::BUS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Event pulses from the link engines, same clock
   input wire logic send_begin_flag,
   input wire logic receive_begin_flag,
   input wire logic send_done_flag,
   input wire logic receive_done_flag,
   input wire logic checksum_fault_flag,
   input wire logic abort_seen_flag,
   input wire logic flag_octet_seen,
   // Kind of the message just finished: 1 message-oriented, valid with receive_done_flag
   input wire logic received_message_kind,
   output logic irq
);
   import hles_pkg::*;

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      hles_bus_state_t wrState;
      logic awHeld;
      logic [BUS_ADDR_W-1:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp;
      hles_bus_state_t rdState;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [EVENT_W-1:0] events;
      logic kind;
      logic [EVENT_W-1:0] enables;
      logic irq;
      // Handshake lines kept as flops so no bus output is decoded
      logic awRdy;
      logic wRdy;
      logic bValid;
      logic arRdy;
      logic rValid;
   } hles_state_t;

   hles_state_t state_r;
   hles_state_t state_nxt;

   logic [EVENT_W-1:0] eventIn;
   logic readStatus;
   logic wrFire;
   logic [BUS_ADDR_W-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;

   // ==========================================================
   // Event gathering
   // ==========================================================
   // Pulses placed at their status positions
   always_comb
   begin
      eventIn = '0;
      eventIn[SEND_BEGIN_BIT] = send_begin_flag;
      eventIn[RECV_BEGIN_BIT] = receive_begin_flag;
      eventIn[SEND_DONE_BIT] = send_done_flag;
      eventIn[RECV_DONE_BIT] = receive_done_flag;
      eventIn[CHECKSUM_BIT] = checksum_fault_flag;
      eventIn[ABORT_BIT] = abort_seen_flag;
      eventIn[FLAG_OCTET_BIT] = flag_octet_seen;
   end

   // Write channels joined from held copies or the live bus
   assign wrAddr = state_r.awHeld ? state_r.awAddr : s_axi_awaddr;
   assign wrData = state_r.wHeld ? state_r.wData : s_axi_wdata;
   assign wrStrb = state_r.wHeld ? state_r.wStrb : s_axi_wstrb;
   assign wrFire = (state_r.wrState == HLES_IDLE) && (state_r.awHeld || s_axi_awvalid)
                   && (state_r.wHeld || s_axi_wvalid);
   assign readStatus = (state_r.rdState == HLES_IDLE) && s_axi_arvalid
                       && (s_axi_araddr == STATUS_ADDR);

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb
   begin
      state_nxt = state_r;

      // Write side: address and data taken in either order
      case (state_r.wrState)
         HLES_IDLE:
         begin
            if (!state_r.awHeld && s_axi_awvalid)
            begin
               state_nxt.awHeld = 1'b1;
               state_nxt.awAddr = s_axi_awaddr;
            end
            if (!state_r.wHeld && s_axi_wvalid)
            begin
               state_nxt.wHeld = 1'b1;
               state_nxt.wData = s_axi_wdata;
               state_nxt.wStrb = s_axi_wstrb;
            end
            if (wrFire)
            begin
               state_nxt.awHeld = 1'b0;
               state_nxt.wHeld = 1'b0;
               state_nxt.wrState = HLES_RESP;
               state_nxt.bResp = RESP_OKAY;
               if (wrAddr == ENABLE_ADDR)
               begin
                  // Low lane carries the whole register; bit 7 is reserved
                  if (wrStrb[0])
                  begin
                     state_nxt.enables = wrData[EVENT_W-1:0];
                  end
               end
               else if (wrAddr != STATUS_ADDR)
               begin
                  // Status is read-only; writes there are accepted and ignored
                  state_nxt.bResp = RESP_SLVERR;
               end
            end
         end
         HLES_RESP:
         begin
            if (s_axi_bready)
            begin
               state_nxt.wrState = HLES_IDLE;
            end
         end
         default:
         begin
            state_nxt.wrState = HLES_IDLE;
         end
      endcase

      // Read side: data is captured in the accept cycle
      case (state_r.rdState)
         HLES_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               state_nxt.rdState = HLES_RESP;
               state_nxt.rResp = RESP_OKAY;
               if (s_axi_araddr == STATUS_ADDR)
               begin
                  state_nxt.rData = {24'h000000, state_r.kind, state_r.events};
               end
               else if (s_axi_araddr == ENABLE_ADDR)
               begin
                  state_nxt.rData = {25'h0000000, state_r.enables};
               end
               else
               begin
                  state_nxt.rData = 32'h00000000;
                  state_nxt.rResp = RESP_SLVERR;
               end
            end
         end
         HLES_RESP:
         begin
            if (s_axi_rready)
            begin
               state_nxt.rdState = HLES_IDLE;
            end
         end
         default:
         begin
            state_nxt.rdState = HLES_IDLE;
         end
      endcase

      // Sticky events; a new pulse in the read cycle survives the clear
      state_nxt.events = (readStatus ? EVENT_RESET : state_r.events) | eventIn;

      // Kind follows each completed reception
      if (receive_done_flag)
      begin
         state_nxt.kind = received_message_kind;
      end

      // Bits 6..0 of enable line up with the event bits one for one
      state_nxt.irq = |(state_nxt.events & state_nxt.enables);

      // Ready and valid follow the next state, so they match it at the same edge
      state_nxt.awRdy = (state_nxt.wrState == HLES_IDLE) && !state_nxt.awHeld;
      state_nxt.wRdy = (state_nxt.wrState == HLES_IDLE) && !state_nxt.wHeld;
      state_nxt.bValid = (state_nxt.wrState == HLES_RESP);
      state_nxt.arRdy = (state_nxt.rdState == HLES_IDLE);
      state_nxt.rValid = (state_nxt.rdState == HLES_RESP);
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r <= '{wrState: HLES_IDLE, awHeld: 1'b0, awAddr: '0, wHeld: 1'b0,
                      wData: 32'h00000000, wStrb: 4'h0, bResp: RESP_OKAY,
                      rdState: HLES_IDLE, rData: 32'h00000000, rResp: RESP_OKAY,
                      events: EVENT_RESET, kind: KIND_RESET, enables: ENABLE_RESET,
                      irq: 1'b0, awRdy: 1'b1, wRdy: 1'b1, bValid: 1'b0,
                      arRdy: 1'b1, rValid: 1'b0};
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Ready lines reflect held state so each channel is taken once
   assign s_axi_awready = state_r.awRdy;
   assign s_axi_wready = state_r.wRdy;
   assign s_axi_bvalid = state_r.bValid;
   assign s_axi_bresp = state_r.bResp;
   assign s_axi_arready = state_r.arRdy;
   assign s_axi_rvalid = state_r.rValid;
   assign s_axi_rdata = state_r.rData;
   assign s_axi_rresp = state_r.rResp;
   assign irq = state_r.irq;

endmodule : hles_link3_event_status

// ===== verilog/hles_pkg.sv
package hles_pkg;

   // ==========================================================
   // Register map (byte addresses on the AXI4-Lite slave)
   // ==========================================================
   localparam int unsigned ADDR_W = 12;
   // Printed offsets are not word aligned: they are register indexes
   localparam logic [ADDR_W-1:0] STATUS_IDX = 12'hB26;
   localparam logic [ADDR_W-1:0] ENABLE_IDX = 12'hB27;
   localparam logic [ADDR_W+1:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
   localparam logic [ADDR_W+1:0] ENABLE_ADDR = {ENABLE_IDX, 2'h0};
   localparam int unsigned BUS_ADDR_W = ADDR_W + 2;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned KIND_BIT = 7;
   localparam int unsigned SEND_BEGIN_BIT = 6;
   localparam int unsigned RECV_BEGIN_BIT = 5;
   localparam int unsigned SEND_DONE_BIT = 4;
   localparam int unsigned RECV_DONE_BIT = 3;
   localparam int unsigned CHECKSUM_BIT = 2;
   localparam int unsigned ABORT_BIT = 1;
   localparam int unsigned FLAG_OCTET_BIT = 0;
   localparam int unsigned EVENT_W = 7;

   // ==========================================================
   // Reset values and bus answers
   // ==========================================================
   localparam logic [EVENT_W-1:0] EVENT_RESET = 7'h00;
   localparam logic [EVENT_W-1:0] ENABLE_RESET = 7'h00;
   localparam logic KIND_RESET = 1'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Slave handshake states
   typedef enum logic [1:0] {HLES_IDLE, HLES_RESP} hles_bus_state_t;

endpackage : hles_pkg
